// ==== sim/mpwm_load_model.sv ====
/*
 * Load on one modulator pin: resolves the pin level and measures runs.
 * Assumes the bench clock; clear is a synchronous pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_load_model (
    input wire logic clock,
    input wire logic clear,
    input wire logic pin_o,
    input wire logic pin_oe,
    output int hi_len,
    output int lo_len,
    output int hi_sum,
    output int hi_max,
    output int lo_max,
    output int falls
);
    logic lvl;
    logic lvl_q = 1'b0;
    int run = 0;

    // Released pin reads low through its pull-down
    assign lvl = pin_oe & pin_o;

    // Start with no falls seen
    initial falls = 0;

    // Run lengths, high total and fall count
    always @(posedge clock) begin
        lvl_q <= lvl;
        run <= (lvl == lvl_q) ? run + 1 : 1;
        if (clear) begin
            hi_sum <= 0;
            hi_max <= 0;
            lo_max <= 0;
        end else begin
            hi_sum <= hi_sum + int'(lvl);
        end
        if (lvl_q && !lvl) begin
            hi_len <= run;
            falls <= falls + 1;
            if (!clear && run > hi_max) hi_max <= run;
        end
        if (!lvl_q && lvl) begin
            lo_len <= run;
            if (!clear && run > lo_max) lo_max <= run;
        end
    end
endmodule

`default_nettype wire

// ==== sim/mpwm_top_assertions.sv ====
/*
 * Port checker for mpwm_top, bound to the top module.
 * Assumes the package register map and a single core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_top_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire mpwm_pkg::mpwm_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic crystal_tick,
    input wire logic vco_tick,
    input wire logic external_counter_clock_in,
    input wire logic output_a_pin_o,
    input wire logic output_a_pin_oe,
    input wire logic output_b_pin_o,
    input wire logic output_b_pin_oe
);
    logic [7:0] ctl_q;
    logic [1:0] age_q;
    logic ctl_wr;
    logic [2:0] md;
    logic off;

    // Control write decode and disabled mode classes
    assign ctl_wr = sfr_req.wr && sfr_req.addr == mpwm_pkg::ADDR_CONTROL;
    assign md = ctl_q[6:4];
    assign off = md == 3'h0 || md >= 3'h5;

    // Shadow control value and cycles since it was written
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            age_q <= 2'h0;
        end else if (ctl_wr) begin
            ctl_q <= sfr_req.wdata & mpwm_pkg::CONTROL_WMASK;
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_off_released;
        off |-> !output_a_pin_oe && !output_b_pin_oe;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("pin driven while disabled");
    property p_off_low;
        off && age_q == 2'h3 |-> !output_a_pin_o && !output_b_pin_o;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("output level high while disabled");
    property p_rsvd;
        ctl_wr && sfr_req.wdata[6:4] == 3'h7 |=> !output_a_pin_oe && !output_b_pin_oe;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved mode drives a pin");
    property p_on_driven;
        md inside {3'h2, 3'h3, 3'h4} |-> output_a_pin_oe && output_b_pin_oe;
    endproperty
    a_on_driven: assert property (p_on_driven)
        else $error("two-output mode leaves a pin released");
    property p_single_b;
        md == 3'h1 |-> output_a_pin_oe && !output_b_pin_oe;
    endproperty
    a_single_b: assert property (p_single_b)
        else $error("single mode pin enables wrong");
    property p_rd_ctl;
        sfr_req.rd && sfr_req.addr == mpwm_pkg::ADDR_CONTROL |=> sfr_rdata == $past(ctl_q);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("control readback wrong");
    property p_rd_hold;
        !sfr_req.rd |=> $stable(sfr_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    property p_m3_sync;
        md == 3'h3 && $past(md, 4) == 3'h3 && $rose(output_b_pin_o)
            |-> $rose(output_a_pin_o) || !output_a_pin_o;
    endproperty
    a_m3_sync: assert property (p_m3_sync)
        else $error("twin 16-bit outputs not started together");
endmodule

bind mpwm_top mpwm_top_assertions u_chk (.clock(clock), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .crystal_tick(crystal_tick), .vco_tick(vco_tick),
    .external_counter_clock_in(external_counter_clock_in), .output_a_pin_o(output_a_pin_o),
    .output_a_pin_oe(output_a_pin_oe), .output_b_pin_o(output_b_pin_o),
    .output_b_pin_oe(output_b_pin_oe));

`default_nettype wire

// ==== sim/mpwm_top_bench.sv ====
/*
 * Self-checking bench for mpwm_top with a load model on each pin.
 * Assumes the bound checker and the package register map.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_top_bench;
    localparam logic [7:0] CT = mpwm_pkg::ADDR_CONTROL;
    localparam logic [7:0] AL = mpwm_pkg::ADDR_A_LOW;
    localparam logic [7:0] BL = mpwm_pkg::ADDR_B_LOW;
    logic clock = 1'b0, rst_n = 1'b0, clr = 1'b0, xt = 1'b0, vco = 1'b0, ext = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [31:0] seed = 32'hBAA7;
    mpwm_pkg::mpwm_sfr_req_s req = '0;
    logic [7:0] rdata;
    logic oa, oae, ob, obe;
    int error_cnt = 0;
    int check_count = 0;
    int hl[2], ll[2], hs[2], hm[2], lm[2], fc[2];

    always #2.5 clock = ~clock;

    // Tick sources: VCO every cycle, crystal every second, external period 4
    always @(posedge clock) begin
        ph <= ph + 2'h1;
        vco <= 1'b1;
        xt <= ph[0];
        ext <= ph[1];
    end

    mpwm_top DUT (.clock(clock), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata),
        .crystal_tick(xt), .vco_tick(vco), .external_counter_clock_in(ext),
        .output_a_pin_o(oa), .output_a_pin_oe(oae), .output_b_pin_o(ob),
        .output_b_pin_oe(obe));
    mpwm_load_model LA (.clock(clock), .clear(clr), .pin_o(oa), .pin_oe(oae), .hi_len(hl[0]),
        .lo_len(ll[0]), .hi_sum(hs[0]), .hi_max(hm[0]), .lo_max(lm[0]), .falls(fc[0]));
    mpwm_load_model LB (.clock(clock), .clear(clr), .pin_o(ob), .pin_oe(obe), .hi_len(hl[1]),
        .lo_len(ll[1]), .hi_sum(hs[1]), .hi_max(hm[1]), .lo_max(lm[1]), .falls(fc[1]));

    // Xorshift source of stimulus bytes
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Expected pin enable for a mode code
    function automatic logic oe_exp(input logic [2:0] m, input bit b);
        return (m inside {3'h2, 3'h3, 3'h4}) || (!b && m == 3'h1);
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        chk("rdata", {24'h0, e}, {24'h0, rdata});
    endtask

    task automatic clr_models();
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
    endtask

    // Wait for n more falls on pin s
    task automatic wt(input int s, input int n);
        int t;
        t = fc[s] + n;
        for (int i = 0; i < 70000 && fc[s] < t; i++) @(negedge clock);
        if (fc[s] < t) begin
            error_cnt++;
            $display("[ERR] falls expected %0d seen %0d", t, fc[s]);
            print_verdict();
        end
    endtask

    // Wait for a fresh rise of output A
    task automatic rise_a();
        for (int i = 0; i < 9000 && oa !== 1'b0; i++) @(negedge clock);
        for (int i = 0; i < 9000 && oa !== 1'b1; i++) @(negedge clock);
        if (oa !== 1'b1) begin
            error_cnt++;
            $display("[ERR] rise of a expected 1 seen %b", oa);
            print_verdict();
        end
    endtask

    initial begin
        logic [7:0] ad[6] = '{CT, AL, mpwm_pkg::ADDR_A_HIGH, BL, mpwm_pkg::ADDR_B_HIGH, 8'hA0};
        int dv[7] = '{1, 4, 16, 64, 30, 2, 4};
        logic [3:0] cf[7] = '{4'h3, 4'h7, 4'hB, 4'hF, 4'h0, 4'h1, 4'h2};
        logic [7:0] p, da, ea, sb;
        logic [15:0] v;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        foreach (ad[i]) rd_chk(ad[i], 8'h00);
        // Every mode code, with the reserved top bit set on write
        for (int m = 0; m < 8; m++) begin
            wr(CT, {1'b1, m[2:0], 4'h3});
            rd_chk(CT, {1'b0, m[2:0], 4'h3});
            chk("oe_a", {31'h0, oe_exp(m[2:0], 1'b0)}, {31'h0, oae});
            chk("oe_b", {31'h0, oe_exp(m[2:0], 1'b1)}, {31'h0, obe});
        end
        // Twin 8-bit: shared period, edges at byte matches
        for (int k = 0; k < 2; k++) begin
            p = 8'h28 + (rnd() & 8'h1F);
            da = 8'h01 + (rnd() & 8'h1F);
            sb = (k == 1) ? 8'h01 + (rnd() & 8'h07) : 8'h00;
            ea = sb + 8'h01 + (rnd() & 8'h0F);
            wr(CT, 8'h23);
            wr(BL, p);
            wr(AL, da);
            wr(mpwm_pkg::ADDR_A_HIGH, ea);
            wr(mpwm_pkg::ADDR_B_HIGH, sb);
            clr_models();
            wt(0, 3);
            chk("a_hi", {24'h0, da}, hl[0]);
            chk("a_lo", p + 1 - da, ll[0]);
            chk("b_hi", {24'h0, ea - sb}, hl[1]);
            if (k == 0) begin
                rise_a();
                chk("b_with_a", 32'h1, {31'h0, ob});
            end
        end
        // Single variable resolution, then a mid-cycle duty update
        v = 16'h0064 + {8'h00, rnd()};
        wr(CT, 8'h13);
        wr16(BL, v);
        wr16(AL, 16'h001E);
        wr(CT, 8'h13);
        clr_models();
        wt(0, 2);
        chk("a_hi", 32'd30, hl[0]);
        chk("a_lo", v + 1 - 30, ll[0]);
        rise_a();
        wr16(AL, 16'h0005);
        wt(0, 1);
        chk("a_old", 32'd30, hl[0]);
        wt(0, 1);
        chk("a_new", 32'd5, hl[0]);
        wr(AL, 8'h09);
        wt(0, 2);
        chk("a_staged", 32'd5, hl[0]);
        // Twin 16-bit over each clock source and prescale
        wr(CT, 8'h33);
        wr16(AL, 16'h0004);
        wr16(BL, 16'h0007);
        wt(1, 1); // Let the long B run from the old value end first
        for (int i = 0; i < 7; i++) begin
            wr(CT, {4'h3, cf[i]});
            wt(1, 1);
            chk("b_minus_a", 3 * dv[i], hl[1] - hl[0]);
        end
        // Sigma-delta over one full 16-bit window
        v = {rnd(), 8'h01};
        wr(CT, 8'h43);
        wr16(AL, v);
        wr16(BL, 16'h4010);
        wr(CT, 8'h43);
        repeat (8) @(posedge clock); // Skip the long low run after the accumulator clear
        clr_models();
        repeat (65536) @(posedge clock);
        @(negedge clock);
        chk("a_sum", {16'h0, v}, hs[0]);
        chk("b_sum", 32'h4010, hs[1]);
        chk("b_hi_max", 32'd1, hm[1]);
        chk("b_lo_max", 32'd3, lm[1]);
        print_verdict();
    end
endmodule

`default_nettype wire

// ==== verilog/mpwm_clock_gen.sv ====
/*
 * Modulator clock generator: picks one of four tick sources and divides
 * it by 1, 4, 16 or 64, giving a one-cycle tick on the core clock.
 * Assumes crystal and VCO ticks come from core-clock logic; the external
 * pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_clock_gen (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [1:0] prescale,
    input wire mpwm_pkg::mpwm_src_e clk_source,
    input wire logic crystal_tick,
    input wire logic vco_tick,
    input wire logic external_counter_clock_in,
    output logic mod_tick
);

    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    logic [3:0] div15_q;
    logic [5:0] pre_q;
    logic [5:0] pre_last;
    logic xtal15_tick;
    logic src_tick;

    // Two-stage synchroniser for the external pin, then edge history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= external_counter_clock_in;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Crystal divide-by-15
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div15_q <= 4'h0;
        end else if (crystal_tick) begin
            div15_q <= (div15_q == mpwm_pkg::XTAL_DIV_LAST) ? 4'h0 : div15_q + 4'h1;
        end
    end

    assign xtal15_tick = crystal_tick && (div15_q == mpwm_pkg::XTAL_DIV_LAST);

    // Source select
    always_comb begin
        case (clk_source)
            mpwm_pkg::SRC_XTAL_DIV15: src_tick = xtal15_tick;
            mpwm_pkg::SRC_XTAL: src_tick = crystal_tick;
            mpwm_pkg::SRC_EXT_PIN: src_tick = ext_sync_q && !ext_prev_q;
            default: src_tick = vco_tick;
        endcase
    end

    // Prescaler terminal count
    always_comb begin
        case (prescale)
            2'b00: pre_last = mpwm_pkg::PRE_LAST_1;
            2'b01: pre_last = mpwm_pkg::PRE_LAST_4;
            2'b10: pre_last = mpwm_pkg::PRE_LAST_16;
            default: pre_last = mpwm_pkg::PRE_LAST_64;
        endcase
    end

    // Prescaler, cleared on a control write so the new divide starts clean
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 6'h00;
        end else if (restart) begin
            pre_q <= 6'h00;
        end else if (src_tick) begin
            pre_q <= (pre_q >= pre_last) ? 6'h00 : pre_q + 6'h01;
        end
    end

    assign mod_tick = src_tick && (pre_q >= pre_last);

endmodule

`default_nettype wire

// ==== verilog/mpwm_pkg.sv ====
/*
 * Shared constants and types of the multimode modulator: register
 * addresses, control field layout, mode codes and clock dividers.
 * Assumes a byte-wide special-function-register port on the core clock.
 */
`default_nettype none

package mpwm_pkg;

    // Register addresses on the byte register port
    localparam logic [7:0] ADDR_CONTROL = 8'hAE;
    localparam logic [7:0] ADDR_A_LOW = 8'hB1;
    localparam logic [7:0] ADDR_A_HIGH = 8'hB2;
    localparam logic [7:0] ADDR_B_LOW = 8'hB3;
    localparam logic [7:0] ADDR_B_HIGH = 8'hB4;

    // Reset values and the control write mask
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h7F;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Counter limits
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hFFFF;

    // Clock divider figures
    localparam logic [3:0] XTAL_DIV_LAST = 4'hE;
    localparam logic [5:0] PRE_LAST_1 = 6'h00;
    localparam logic [5:0] PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_SINGLE = 3'b001,
        MODE_TWIN8 = 3'b010,
        MODE_TWIN16 = 3'b011,
        MODE_SD_NRZ = 3'b100,
        MODE_DUAL8 = 3'b101,
        MODE_SD_RZ = 3'b110,
        MODE_RSVD = 3'b111
    } mpwm_mode_e;

    typedef enum logic [1:0] {
        SRC_XTAL_DIV15 = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_EXT_PIN = 2'b10,
        SRC_VCO = 2'b11
    } mpwm_src_e;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic reserved;
        mpwm_mode_e mode;
        logic [1:0] prescale;
        mpwm_src_e clk_source;
    } mpwm_control_s;

    // One register port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mpwm_sfr_req_s;

endpackage

`default_nettype wire

// ==== verilog/mpwm_sd_channel.sv ====
/*
 * First-order sigma-delta channel: a 16-bit accumulator adds the data
 * value on each modulator tick; the carry is the registered output bit.
 * Assumes tick and clear are single-cycle pulses on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_sd_channel (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic [15:0] value,
    output logic bit_out
);

    logic [15:0] acc_q;
    logic [16:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, value};

    // Accumulate and emit carry on every modulator tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 16'h0000;
            bit_out <= 1'b0;
        end else if (clear) begin
            acc_q <= 16'h0000;
            bit_out <= 1'b0;
        end else if (tick) begin
            acc_q <= sum[15:0];
            bit_out <= sum[16];
        end
    end

endmodule

`default_nettype wire

// ==== verilog/mpwm_top.sv ====
/*
 * Two-output multimode modulator with its control and data registers
 * on a byte-wide register port. Covers disabled, single variable
 * resolution, twin 8-bit, twin 16-bit and NRZ sigma-delta operation.
 * Assumes register accesses are single-cycle strobes on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mpwm_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire mpwm_pkg::mpwm_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic crystal_tick,
    input wire logic vco_tick,
    input wire logic external_counter_clock_in,
    output logic output_a_pin_o,
    output logic output_a_pin_oe,
    output logic output_b_pin_o,
    output logic output_b_pin_oe
);

    mpwm_pkg::mpwm_control_s control_q;
    logic [7:0] data_a_low_q;
    logic [7:0] data_a_high_q;
    logic [7:0] data_b_low_q;
    logic [7:0] data_b_high_q;
    logic [7:0] stage_a_q;
    logic [7:0] stage_b_q;
    logic [15:0] act_a_q;
    logic [15:0] act_b_q;
    logic [15:0] cnt_q;
    logic out_a_q;
    logic out_b_q;
    logic ctrl_wr;
    logic mod_tick;
    logic wrap;
    logic cycle_end;
    logic mode16;
    logic active;
    logic sd_a;
    logic sd_b;
    mpwm_pkg::mpwm_mode_e mode;

    // True for an access that hits a given register address
    function automatic logic hit(input logic strobe, input logic [7:0] a,
                                 input logic [7:0] target);
        hit = strobe && (a == target);
    endfunction

    assign mode = control_q.mode;
    assign ctrl_wr = hit(sfr_req.wr, sfr_req.addr, mpwm_pkg::ADDR_CONTROL);

    // Modes whose data pairs are double-buffered 16-bit values
    assign mode16 = (mode == mpwm_pkg::MODE_SINGLE) || (mode == mpwm_pkg::MODE_TWIN16)
                 || (mode == mpwm_pkg::MODE_SD_NRZ) || (mode == mpwm_pkg::MODE_SD_RZ);

    // Modes this block drives; 0, 5, 6 and 7 leave pins released
    assign active = (mode == mpwm_pkg::MODE_SINGLE) || (mode == mpwm_pkg::MODE_TWIN8)
                 || (mode == mpwm_pkg::MODE_TWIN16) || (mode == mpwm_pkg::MODE_SD_NRZ);

    // Control register; bit 7 is never stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= mpwm_pkg::CONTROL_RESET;
        end else if (ctrl_wr) begin
            control_q <= sfr_req.wdata & mpwm_pkg::CONTROL_WMASK;
        end
    end

    // Data registers with hidden low-byte staging
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_a_low_q <= mpwm_pkg::DATA_RESET;
            data_a_high_q <= mpwm_pkg::DATA_RESET;
            data_b_low_q <= mpwm_pkg::DATA_RESET;
            data_b_high_q <= mpwm_pkg::DATA_RESET;
            stage_a_q <= mpwm_pkg::DATA_RESET;
            stage_b_q <= mpwm_pkg::DATA_RESET;
        end else begin
            if (hit(sfr_req.wr, sfr_req.addr, mpwm_pkg::ADDR_A_LOW)) begin
                stage_a_q <= sfr_req.wdata;
                if (!mode16) begin
                    data_a_low_q <= sfr_req.wdata;
                end
            end
            if (hit(sfr_req.wr, sfr_req.addr, mpwm_pkg::ADDR_A_HIGH)) begin
                data_a_high_q <= sfr_req.wdata;
                if (mode16) begin
                    data_a_low_q <= stage_a_q;
                end
            end
            if (hit(sfr_req.wr, sfr_req.addr, mpwm_pkg::ADDR_B_LOW)) begin
                stage_b_q <= sfr_req.wdata;
                if (!mode16) begin
                    data_b_low_q <= sfr_req.wdata;
                end
            end
            if (hit(sfr_req.wr, sfr_req.addr, mpwm_pkg::ADDR_B_HIGH)) begin
                data_b_high_q <= sfr_req.wdata;
                if (mode16) begin
                    data_b_low_q <= stage_b_q;
                end
            end
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= mpwm_pkg::READ_IDLE;
        end else if (sfr_req.rd) begin
            if (sfr_req.addr == mpwm_pkg::ADDR_CONTROL) begin
                sfr_rdata <= control_q;
            end else if (sfr_req.addr == mpwm_pkg::ADDR_A_LOW) begin
                sfr_rdata <= data_a_low_q;
            end else if (sfr_req.addr == mpwm_pkg::ADDR_A_HIGH) begin
                sfr_rdata <= data_a_high_q;
            end else if (sfr_req.addr == mpwm_pkg::ADDR_B_LOW) begin
                sfr_rdata <= data_b_low_q;
            end else if (sfr_req.addr == mpwm_pkg::ADDR_B_HIGH) begin
                sfr_rdata <= data_b_high_q;
            end else begin
                sfr_rdata <= mpwm_pkg::READ_IDLE;
            end
        end
    end

    mpwm_clock_gen u_clock_gen (
        .clock(clock),
        .rst_n(rst_n),
        .restart(ctrl_wr),
        .prescale(control_q.prescale),
        .clk_source(control_q.clk_source),
        .crystal_tick(crystal_tick),
        .vco_tick(vco_tick),
        .external_counter_clock_in(external_counter_clock_in),
        .mod_tick(mod_tick)
    );

    // Counter end-of-cycle per mode
    always_comb begin
        case (mode)
            mpwm_pkg::MODE_SINGLE: wrap = (cnt_q >= act_b_q);
            mpwm_pkg::MODE_TWIN8: wrap = (cnt_q[7:0] >= data_b_low_q);
            default: wrap = (cnt_q == mpwm_pkg::COUNT_FULL);
        endcase
    end

    assign cycle_end = mod_tick && wrap;

    // Modulator counter, restarted by any control write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= mpwm_pkg::COUNT_ZERO;
        end else if (ctrl_wr || !active) begin
            cnt_q <= mpwm_pkg::COUNT_ZERO;
        end else if (cycle_end) begin
            cnt_q <= mpwm_pkg::COUNT_ZERO;
        end else if (mod_tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Working 16-bit values, taken over at cycle end, at restart and on every cycle while inactive
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            act_a_q <= mpwm_pkg::COUNT_ZERO;
            act_b_q <= mpwm_pkg::COUNT_ZERO;
        end else if (ctrl_wr || cycle_end || !active) begin
            act_a_q <= {data_a_high_q, data_a_low_q};
            act_b_q <= {data_b_high_q, data_b_low_q};
        end
    end

    mpwm_sd_channel u_sd_a (
        .clock(clock),
        .rst_n(rst_n),
        .clear(ctrl_wr),
        .tick(mod_tick),
        .value(act_a_q),
        .bit_out(sd_a)
    );

    mpwm_sd_channel u_sd_b (
        .clock(clock),
        .rst_n(rst_n),
        .clear(ctrl_wr),
        .tick(mod_tick),
        .value(act_b_q),
        .bit_out(sd_b)
    );

    // Output levels from the counter position in each PWM mode, from the sigma-delta carries in NRZ mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            case (mode)
                mpwm_pkg::MODE_SINGLE: begin
                    out_a_q <= (cnt_q < act_a_q);
                    out_b_q <= 1'b0;
                end
                mpwm_pkg::MODE_TWIN8: begin
                    out_a_q <= (cnt_q[7:0] < data_a_low_q);
                    out_b_q <= (cnt_q[7:0] >= data_b_high_q)
                            && (cnt_q[7:0] < data_a_high_q);
                end
                mpwm_pkg::MODE_TWIN16: begin
                    out_a_q <= (cnt_q < act_a_q);
                    out_b_q <= (cnt_q < act_b_q);
                end
                mpwm_pkg::MODE_SD_NRZ: begin
                    out_a_q <= sd_a;
                    out_b_q <= sd_b;
                end
                default: begin
                    out_a_q <= 1'b0;
                    out_b_q <= 1'b0;
                end
            endcase
        end
    end

    // Pin drive; mode 1 uses only output A
    assign output_a_pin_o = out_a_q;
    assign output_b_pin_o = out_b_q;
    assign output_a_pin_oe = active;
    assign output_b_pin_oe = active && (mode != mpwm_pkg::MODE_SINGLE);

endmodule

`default_nettype wire
